// ===== verilog/lopmc_regs.sv
// serial programming port and oscillator path and mode control registers
//
// Function
// - path register 0x4F resets 0x7000; bits 14-12 enable oscillator path parts
// - path bit 6 switches amplifier input pull-up, for common mode below 1.4V
// - path bit 1 holds the whole signal chain in reset while set
// - path bit 0 powers down signal chain, bit 2 front amplifier; reset zero
// - sync register 0x50 resets 0xA; bit 11 closes mixer-to-synth loop
// - sync bit 10 enables second-stage alignment driver
// - sync bit 9 enables first-stage alignment driver
// - sync bits 5-0 route select, reset 0xA; 0x9 halving, 0x10 poly
// - mode register 0x51 resets zero; bits 11-8 set polyphase path setup
// - mode bits 7-6 choose machine clock driver; 0x0 internal, 0x3 external
// - mode bits 5-4 set quadrature drivers: poly, halving, reserved, external
// - mode bits 2-1 enable machine clock drivers, reset zero
// - mode bit 0 picks machine clock source: 0 internal, 1 external
// - six-bit divide field sets external oscillator machine clock division
`timescale 1ns/10ps
module lopmc_regs
  import lopmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sck,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  output lopmc_ctrl_s      ctrl
);

  // register storage
  logic [15:0] path_reg;
  logic [15:0] sync_reg;
  logic [15:0] mode_reg;
  logic [15:0] xdiv_reg;

  // serial port state
  logic        sck_reg;
  logic        cs_n_reg;
  logic [4:0]  cnt_reg;
  logic [23:0] rx_reg;
  logic [15:0] tx_reg;
  logic        rd_reg;
  logic        sdo_reg;
  logic        oe_reg;

  // edge and frame decode
  wire         sck_rise  = spi_sck & ~sck_reg;
  wire         sck_fall  = ~spi_sck & sck_reg;
  wire         cs_rise   = spi_cs_n & ~cs_n_reg;
  wire         take_bit  = ~spi_cs_n & sck_rise & (cnt_reg < 5'(FRAME_BITS));
  wire         head_done = take_bit & (cnt_reg == 5'(HEAD_BITS - 1));
  wire [6:0]   head_addr = {rx_reg[5:0], spi_sdi};
  wire         head_rd   = rx_reg[6];
  wire         wr_frame  = cs_rise & (cnt_reg == 5'(FRAME_BITS)) & ~rx_reg[23];
  wire [6:0]   wr_addr   = rx_reg[22:16];
  wire [15:0]  wr_data   = rx_reg[15:0];
  wire         shift_out = ~spi_cs_n & sck_fall & rd_reg
                           & (cnt_reg >= 5'(HEAD_BITS));

  // address decode for writes
  wire         wr_path = wr_frame & (wr_addr == ADDR_PATH);
  wire         wr_sync = wr_frame & (wr_addr == ADDR_SYNC);
  wire         wr_mode = wr_frame & (wr_addr == ADDR_MODE);
  wire         wr_xdiv = wr_frame & (wr_addr == ADDR_XDIV);

  // read word selection, unmapped addresses read zero
  logic [15:0] rd_word;
  always_comb begin
    if (head_addr == ADDR_PATH) begin
      rd_word = path_reg;
    end else if (head_addr == ADDR_SYNC) begin
      rd_word = sync_reg;
    end else if (head_addr == ADDR_MODE) begin
      rd_word = mode_reg;
    end else if (head_addr == ADDR_XDIV) begin
      rd_word = xdiv_reg;
    end else begin
      rd_word = 16'h0000;
    end
  end

  // pin history for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_reg  <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      sck_reg  <= spi_sck;
      cs_n_reg <= spi_cs_n;
    end
  end

  // receive shifter and bit count, cleared while deselected
  always_ff @(posedge clk) begin
    if (!rst_n || spi_cs_n) begin
      cnt_reg <= 5'h0;
      rx_reg  <= 24'h00_0000;
    end else if (take_bit) begin
      cnt_reg <= cnt_reg + 5'h1;
      rx_reg  <= {rx_reg[22:0], spi_sdi};
    end
  end

  // read path, data leaves on falling clock edges
  always_ff @(posedge clk) begin
    if (!rst_n || spi_cs_n) begin
      rd_reg  <= 1'b0;
      tx_reg  <= 16'h0000;
      sdo_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (head_done) begin
      rd_reg  <= head_rd;
      tx_reg  <= rd_word;
      oe_reg  <= head_rd;
    end else if (shift_out) begin
      sdo_reg <= tx_reg[15];
      tx_reg  <= {tx_reg[14:0], 1'b0};
    end
  end

  // register writes commit when a full write frame ends
  // reserved masked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      path_reg <= RST_PATH;
      sync_reg <= RST_SYNC;
      mode_reg <= RST_MODE;
      xdiv_reg <= RST_XDIV;
    end else begin
      if (wr_path) begin
        path_reg <= wr_data & MASK_PATH;
      end
      if (wr_sync) begin
        sync_reg <= wr_data & MASK_SYNC;
      end
      if (wr_mode) begin
        mode_reg <= wr_data & MASK_MODE;
      end
      if (wr_xdiv) begin
        xdiv_reg <= wr_data & MASK_XDIV;
      end
    end
  end

  assign spi_sdo    = sdo_reg;
  assign spi_sdo_oe = oe_reg;

  // path register fields
  // path enables
  assign ctrl.osc_path_enables        = path_reg[PATH_EN_LSB +: 3];
  assign ctrl.amp_input_pullup_enable = path_reg[PULLUP_BIT];
  assign ctrl.signal_chain_reset      = path_reg[CHAIN_RST_BIT];
  assign ctrl.front_amp_powerdown     = path_reg[AMP_PD_BIT];
  assign ctrl.signal_chain_powerdown  = path_reg[CHAIN_PD_BIT];

  // sync register fields
  // loop close
  assign ctrl.phase_loop_close                 = sync_reg[LOOP_BIT];
  assign ctrl.second_stage_align_driver_enable = sync_reg[DRV2_BIT];
  assign ctrl.first_stage_align_driver_enable  = sync_reg[DRV1_BIT];
  assign ctrl.osc_route_select                 = sync_reg[ROUTE_LSB +: 6];

  // mode and divide register fields
  // polyphase setup
  assign ctrl.polyphase_path_setup        = mode_reg[POLY_LSB +: 4];
  assign ctrl.machine_clock_driver_select = mode_reg[MDRV_SEL_LSB +: 2];
  assign ctrl.quadrature_driver_mode      = mode_reg[QDRV_LSB +: 2];
  assign ctrl.machine_clock_driver_enable = mode_reg[MDRV_EN_LSB +: 2];
  assign ctrl.machine_clock_source_select = mode_reg[MSRC_BIT];
  assign ctrl.outside_osc_clock_divide    = xdiv_reg[XDIV_LSB +: 6];

  // checks on the register bank
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_to(logic [6:0] a);
    wr_frame && (wr_addr == a);
  endsequence

  a_reset_values: assert property (
    !$past(rst_n) |-> (path_reg == RST_PATH) && (sync_reg == RST_SYNC)
                      && (mode_reg == RST_MODE) && (xdiv_reg == RST_XDIV))
    else $error("register reset value wrong");

  a_reserved_zero: assert property (
    ((path_reg & ~MASK_PATH) == 16'h0000) && ((sync_reg & ~MASK_SYNC) == 16'h0000)
    && ((mode_reg & ~MASK_MODE) == 16'h0000) && ((xdiv_reg & ~MASK_XDIV) == 16'h0000))
    else $error("reserved bit set");

  a_path_commit: assert property (
    s_write_to(ADDR_PATH) |=> (ctrl.signal_chain_reset == $past(wr_data[CHAIN_RST_BIT]))
                           && (ctrl.signal_chain_powerdown == $past(wr_data[CHAIN_PD_BIT]))
                           && (ctrl.osc_path_enables == $past(wr_data[14:12])))
    else $error("path register write not applied");

  a_sync_commit: assert property (
    s_write_to(ADDR_SYNC) |=> (ctrl.phase_loop_close == $past(wr_data[LOOP_BIT]))
                           && (ctrl.osc_route_select == $past(wr_data[5:0])))
    else $error("sync register write not applied");

  a_mode_commit: assert property (
    s_write_to(ADDR_MODE) |=> (mode_reg == ($past(wr_data) & MASK_MODE))
                           && (ctrl.machine_clock_source_select == $past(wr_data[0])))
    else $error("mode register write not applied");

  a_xdiv_commit: assert property (
    s_write_to(ADDR_XDIV) |=> (ctrl.outside_osc_clock_divide == $past(wr_data[5:0])))
    else $error("divide register write not applied");

  a_short_frame: assert property (
    (cs_rise && (cnt_reg != 5'(FRAME_BITS))) |=>
      $stable(path_reg) && $stable(sync_reg) && $stable(mode_reg) && $stable(xdiv_reg))
    else $error("incomplete frame changed a register");

  a_read_drive: assert property (
    (head_done && head_rd) |=> (spi_sdo_oe until spi_cs_n))
    else $error("read data not driven");

  a_read_first: assert property (
    (shift_out && (cnt_reg == 5'(HEAD_BITS))) |=> (spi_sdo == $past(tx_reg[15])))
    else $error("first read bit wrong");

  a_pullup_commit: assert property (
    s_write_to(ADDR_PATH) |=>
      (ctrl.amp_input_pullup_enable == $past(wr_data[PULLUP_BIT])))
    else $error("pull-up bit write not applied");

  a_amp_powerdown: assert property (
    s_write_to(ADDR_PATH) |=>
      (ctrl.front_amp_powerdown == $past(wr_data[AMP_PD_BIT])))
    else $error("front amplifier power down write not applied");

  a_drv2_commit: assert property (
    s_write_to(ADDR_SYNC) |=>
      (ctrl.second_stage_align_driver_enable == $past(wr_data[DRV2_BIT])))
    else $error("second driver enable write not applied");

  a_drv1_commit: assert property (
    s_write_to(ADDR_SYNC) |=>
      (ctrl.first_stage_align_driver_enable == $past(wr_data[DRV1_BIT])))
    else $error("first driver enable write not applied");

  a_poly_commit: assert property (
    s_write_to(ADDR_MODE) |=>
      (ctrl.polyphase_path_setup == $past(wr_data[POLY_LSB +: 4])))
    else $error("polyphase setup write not applied");

  a_mdrv_select: assert property (
    s_write_to(ADDR_MODE) |=>
      (ctrl.machine_clock_driver_select == $past(wr_data[MDRV_SEL_LSB +: 2])))
    else $error("clock driver select write not applied");

  a_qdrv_commit: assert property (
    s_write_to(ADDR_MODE) |=>
      (ctrl.quadrature_driver_mode == $past(wr_data[QDRV_LSB +: 2])))
    else $error("quadrature driver write not applied");

  a_mdrv_enable: assert property (
    s_write_to(ADDR_MODE) |=>
      (ctrl.machine_clock_driver_enable == $past(wr_data[MDRV_EN_LSB +: 2])))
    else $error("clock driver enable write not applied");

  a_unmapped_write: assert property (
    (wr_frame && !wr_path && !wr_sync && !wr_mode && !wr_xdiv) |=>
      $stable(path_reg) && $stable(sync_reg) && $stable(mode_reg) && $stable(xdiv_reg))
    else $error("unmapped write changed a register");

  a_reg_hold: assert property (
    !wr_frame |=>
      $stable(path_reg) && $stable(sync_reg) && $stable(mode_reg) && $stable(xdiv_reg))
    else $error("register changed without a write");

  a_unmapped_read: assert property (
    (head_done && head_rd && (head_addr != ADDR_PATH) && (head_addr != ADDR_SYNC)
     && (head_addr != ADDR_MODE) && (head_addr != ADDR_XDIV)) |=> (tx_reg == 16'h0000))
    else $error("unmapped read returned data");

endmodule // lopmc_regs

// ===== pkg/lopmc_pkg.sv
// constants and carrier types for the oscillator path and mode control registers
package lopmc_pkg;

  // serial frame layout: one direction bit, seven address bits, sixteen data bits
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned HEAD_BITS  = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 16;

  // register addresses
  localparam logic [6:0] ADDR_PATH = 7'h4F;
  localparam logic [6:0] ADDR_SYNC = 7'h50;
  localparam logic [6:0] ADDR_MODE = 7'h51;
  localparam logic [6:0] ADDR_XDIV = 7'h52;

  // reset values
  localparam logic [15:0] RST_PATH = 16'h7000;
  localparam logic [15:0] RST_SYNC = 16'h000A;
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_XDIV = 16'h0023;

  // writable bit masks, everything else reads zero
  localparam logic [15:0] MASK_PATH = 16'h7047;
  localparam logic [15:0] MASK_SYNC = 16'h0E3F;
  localparam logic [15:0] MASK_MODE = 16'h0FF7;
  localparam logic [15:0] MASK_XDIV = 16'h003F;

  // field positions
  localparam int unsigned PATH_EN_LSB   = 12;
  localparam int unsigned PULLUP_BIT    = 6;
  localparam int unsigned AMP_PD_BIT    = 2;
  localparam int unsigned CHAIN_RST_BIT = 1;
  localparam int unsigned CHAIN_PD_BIT  = 0;
  localparam int unsigned LOOP_BIT      = 11;
  localparam int unsigned DRV2_BIT      = 10;
  localparam int unsigned DRV1_BIT      = 9;
  localparam int unsigned ROUTE_LSB     = 0;
  localparam int unsigned POLY_LSB      = 8;
  localparam int unsigned MDRV_SEL_LSB  = 6;
  localparam int unsigned QDRV_LSB      = 4;
  localparam int unsigned MDRV_EN_LSB   = 1;
  localparam int unsigned MSRC_BIT      = 0;
  localparam int unsigned XDIV_LSB      = 0;

  // control fields as seen by the analog side
  typedef struct packed {
    logic [2:0] osc_path_enables;
    logic       amp_input_pullup_enable;
    logic       front_amp_powerdown;
    logic       signal_chain_reset;
    logic       signal_chain_powerdown;
    logic       phase_loop_close;
    logic       second_stage_align_driver_enable;
    logic       first_stage_align_driver_enable;
    logic [5:0] osc_route_select;
    logic [3:0] polyphase_path_setup;
    logic [1:0] machine_clock_driver_select;
    logic [1:0] quadrature_driver_mode;
    logic [1:0] machine_clock_driver_enable;
    logic       machine_clock_source_select;
    logic [5:0] outside_osc_clock_divide;
  } lopmc_ctrl_s;

endpackage

// ===== bench/lopmc_regs_tb.sv
// self-checking bench for the oscillator path and mode control registers
`timescale 1ns/10ps
module lopmc_regs_tb
  import lopmc_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        cs_n;
  logic        sck;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  lopmc_ctrl_s ctrl;
  logic [15:0] m [4];
  logic [15:0] rd;
  logic [6:0]  a;
  int          fails;
  int          compares;
  logic [15:0] codes [9] = '{16'h0009, 16'h0010, 16'h0000, 16'h0500, 16'h0900,
                             16'h0042, 16'h0095, 16'h00A0, 16'h00F7};

  lopmc_regs u_lopmc_regs (
    .clk        (clk),
    .rst_n      (rst_n),
    .spi_cs_n   (cs_n),
    .spi_sck    (sck),
    .spi_sdi    (sdi),
    .spi_sdo    (sdo),
    .spi_sdo_oe (sdo_oe),
    .ctrl       (ctrl)
  );

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // writable bits of each mapped address
  function automatic logic [15:0] mask_of(input logic [6:0] x);
    case (x)
      ADDR_PATH: return MASK_PATH;
      ADDR_SYNC: return MASK_SYNC;
      ADDR_MODE: return MASK_MODE;
      ADDR_XDIV: return MASK_XDIV;
      default:   return 16'h0000;
    endcase
  endfunction

  // control fields expected from the mirror
  function automatic lopmc_ctrl_s exp_ctrl();
    return {m[0][14:12], m[0][6], m[0][2:0], m[1][11:9], m[1][5:0], m[2][11:4],
            m[2][2:0], m[3][5:0]};
  endfunction

  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    m = '{RST_PATH, RST_SYNC, RST_MODE, RST_XDIV};
  endtask

  // one serial frame of n bits; read data gathered after sck falls 8 to 23
  task automatic frame(input logic rw, input logic [6:0] x, input logic [15:0] d,
                       input int n);
    logic [23:0] w;
    w = {rw, x, d};
    rd = 16'h0000;
    cs_n <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sdi <= w[23-i];
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      sck <= 1'b0;
      repeat (3) @(posedge clk);
      if (rw && i >= 7 && i <= 22) rd[22-i] = sdo;
      if (rw && i == 7) chk("sdo_oe", 33'(1), 33'(sdo_oe));
    end
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] x, input logic [15:0] d);
    frame(1'b0, x, d, 24);
    if (mask_of(x) != 16'h0000) m[2'(x - ADDR_PATH)] = d & mask_of(x);
  endtask

  task automatic rdchk(input logic [6:0] x);
    logic [15:0] e;
    e = (mask_of(x) != 16'h0000) ? m[2'(x - ADDR_PATH)] : 16'h0000;
    frame(1'b1, x, 16'($urandom()), 24);
    chk("read data", 33'(e), 33'(rd));
    chk("sdo_oe idle", 33'(0), 33'(sdo_oe));
    chk("ctrl", 33'(exp_ctrl()), 33'(ctrl));
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    fails = 0;
    compares = 0;
    void'($urandom(32'hb0be));
    do_reset();
    for (int k = 0; k < 4; k++) rdchk(ADDR_PATH + 7'(k));
    rdchk(7'h00);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_PATH + 7'(k % 4), (k < 4) ? 16'hFFFF : 16'h0000);
      rdchk(ADDR_PATH + 7'(k % 4));
    end
    $display("test masks done");
    // codes for each oscillator mode stored
    for (int k = 0; k < 9; k++) begin
      wr((k < 2) ? ADDR_SYNC : ADDR_MODE, codes[k]);
      rdchk((k < 2) ? ADDR_SYNC : ADDR_MODE);
    end
    $display("test codes done");
    repeat (30) begin
      a = 7'h4D + 7'($urandom() % 7);
      wr(a, 16'($urandom()));
      rdchk(a);
    end
    $display("test random done");
    frame(1'b0, ADDR_PATH, ~m[0], 23);
    rdchk(ADDR_PATH);
    $display("test short frame done");
    do_reset();
    for (int k = 0; k < 4; k++) rdchk(ADDR_PATH + 7'(k));
    $display("test rerun reset done");
    final_report();
  end
endmodule // lopmc_regs_tb
